// ==== hdl/dsp_irq_params.svh ====
// constants for the interrupt control and converter data block
`ifndef DSP_IRQ_PARAMS_SVH
`define DSP_IRQ_PARAMS_SVH
`define BIT_HOST_PEND 15
`define BIT_ADC_PEND 14
`define BIT_DAC_PEND 13
`define BIT_MASK_HIGH 12
`define BIT_MASK_MID 11
`define BIT_MASK_LOW 10
`define BIT_CROSS_REQ 9
`define BIT_GLOBAL_EN 8
`define ROUTE_MSB 7
`define ROUTE_LSB 5
`define BIT_HOST_CLR 4
`define BIT_ADC_CLR 3
`define BIT_DAC_CLR 2
`define DAC_WIDTH 10
`define ADC_LSB 2
`define ADC_MSB 9
`define CTRL_RESET 16'h0000
`define ACK_DELAY_INSTR 3
`endif

// ==== hdl/dsp_irq_pkg.sv ====
// types for the interrupt control and converter data block
package dsp_irq_pkg;
    typedef enum logic [2:0] {
        ROUTE_HML = 3'b000,
        ROUTE_MHL = 3'b001,
        ROUTE_HLM = 3'b010,
        ROUTE_MLH = 3'b011,
        ROUTE_LHM = 3'b100,
        ROUTE_LMH = 3'b101,
        ROUTE_RSV6 = 3'b110,
        ROUTE_RSV7 = 3'b111
    } route_t;
    typedef enum logic [1:0] {
        SVC_IDLE = 2'b00,
        SVC_BUSY = 2'b01
    } svc_state_t;
endpackage

// ==== hdl/pending_flag.sv ====
// one sticky pending flag with set-over-clear
`timescale 1ns/10ps
module pending_flag (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // set and clear strobes
    input wire logic setPulse,
    input wire logic clrPulse,
    // flag
    output logic flag
);
    logic flag_ff;
    // the set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_ff <= 1'b0;
        end else if (setPulse) begin
            flag_ff <= 1'b1;
        end else if (clrPulse) begin
            flag_ff <= 1'b0;
        end
    end
    assign flag = flag_ff;
endmodule

// ==== hdl/ack_delay.sv ====
// counts host instruction strobes after an acknowledge and fires once
`timescale 1ns/10ps
`include "dsp_irq_params.svh"
module ack_delay (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // acknowledge and instruction strobe
    input wire logic ackWrite,
    input wire logic instrStep,
    // fire when the delay ends
    output logic fire
);
    logic [1:0] count_ff;
    logic armed_ff;
    logic fire_ff;
    // arm on acknowledge, count instructions, pulse at the third
    always_ff @(posedge clk) begin
        if (!resetn) begin
            armed_ff <= 1'b0;
            count_ff <= 2'h0;
            fire_ff <= 1'b0;
        end else begin
            fire_ff <= 1'b0;
            if (ackWrite) begin
                armed_ff <= 1'b1;
                count_ff <= 2'h0;
            end else if (armed_ff && instrStep) begin
                if (count_ff == 2'(`ACK_DELAY_INSTR - 1)) begin
                    armed_ff <= 1'b0;
                    fire_ff <= 1'b1;
                end
                count_ff <= count_ff + 2'h1;
            end
        end
    end
    assign fire = fire_ff;
endmodule

// ==== hdl/dsp_interrupt_and_converter_data.sv ====
// interrupt control register and converter data register of the signal processor
// How it works
// RULE1: bit15 host request pending, set by host only
// RULE2: bit14 pending when A/D data valid
// RULE3: bit13 pending on D/A rate tick
// RULE4: write one to bits 4..2 clears flags
// RULE5: clear bits read zero, no storage
// RULE6: bits 12..10 mask high, mid, low levels
// RULE7: bit8 global enable gates all interrupts
// RULE8: reset clears global enable
// RULE9: bit9 write drives host request; reads zero
// RULE10: host acknowledges by writing link control D0
// RULE11: request auto-clears three host instructions later
// RULE12: routing codes 000, 001, 010 as listed
// RULE13: routing codes 011, 100, 101; 110/111 reserved
// RULE14: data write passes ten bits to D/A
// RULE15: data read gives A/D in bits 9..2
// RULE16: high over mid over low, no nesting
// RULE17: host sees only bits 15 and 9
// RULE18: data read clears conversion-done status
// RULE19: level requests when pending, unmasked, enabled
// RULE20: bits 1..0 reserved, read zero
`timescale 1ns/10ps
`include "dsp_irq_params.svh"
module dsp_interrupt_and_converter_data
    import dsp_irq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // signal processor register port
    input wire logic ctrlSel,
    input wire logic dataSel,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    // host side
    input wire logic hostRequestSet,
    input wire logic hostAckWrite,
    input wire logic hostInstrStep,
    output logic [1:0] hostReadBits,
    output logic crossRequestToHost,
    // converters and timer
    input wire logic adcValid,
    input wire logic [7:0] adcData,
    input wire logic dacRateTick,
    output logic [9:0] dacData,
    output logic dacLoad,
    output logic convDoneClear,
    // processor interrupt side
    input wire logic serviceEnd,
    output logic [2:0] levelRequest,
    output logic [1:0] levelTaken,
    output logic levelTakenValid
);
    logic [15:0] ctrl_ff;
    logic hostPend, adcPend, dacPend;
    logic ctrlWr, dataWr, dataRd, ackFire;
    logic cross_ff;
    logic [15:0] rdata_ff;
    logic [9:0] dac_ff;
    logic dacLoad_ff, convClr_ff;
    logic [2:0] lvlReq_ff, nxt_lvlReq;
    logic [2:0] srcLevel [3];
    logic [1:0] taken_ff;
    logic takenValid_ff;
    svc_state_t svc_ff;
    route_t route;

    assign ctrlWr = ctrlSel && regWrite;
    assign dataWr = dataSel && regWrite;
    assign dataRd = dataSel && regRead;
    assign route = route_t'(ctrl_ff[`ROUTE_MSB:`ROUTE_LSB]);

    // pending flags; clear strobes are write-one only
    pending_flag u_host (.clk(clk), .resetn(resetn), .setPulse(hostRequestSet), // RULE1
        .clrPulse(ctrlWr && regWdata[`BIT_HOST_CLR]), .flag(hostPend)); // RULE4
    pending_flag u_adc (.clk(clk), .resetn(resetn), .setPulse(adcValid), // RULE2
        .clrPulse(ctrlWr && regWdata[`BIT_ADC_CLR]), .flag(adcPend)); // RULE4
    pending_flag u_dac (.clk(clk), .resetn(resetn), .setPulse(dacRateTick), // RULE3
        .clrPulse(ctrlWr && regWdata[`BIT_DAC_CLR]), .flag(dacPend)); // RULE4

    // stored control fields: masks, global enable, routing
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_ff <= `CTRL_RESET; // RULE8
        end else if (ctrlWr) begin
            ctrl_ff <= regWdata & 16'h1de0; // RULE6 RULE7 RULE5 RULE20
        end
    end

    // host acknowledge delay
    ack_delay u_ack (
        .clk(clk),
        .resetn(resetn),
        .ackWrite(hostAckWrite), // RULE10
        .instrStep(hostInstrStep),
        .fire(ackFire)
    );

    // cross request toward the host; a write wins over the automatic clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cross_ff <= 1'b0;
        end else if (ctrlWr) begin
            cross_ff <= regWdata[`BIT_CROSS_REQ]; // RULE9
        end else if (ackFire) begin
            cross_ff <= 1'b0; // RULE11
        end
    end

    // routing of sources onto levels, index 0 host, 1 adc, 2 dac; bit2 high
    always_comb begin
        unique case (route)
            ROUTE_HML: srcLevel = '{3'b100, 3'b010, 3'b001}; // RULE12
            ROUTE_MHL: srcLevel = '{3'b010, 3'b100, 3'b001}; // RULE12
            ROUTE_HLM: srcLevel = '{3'b100, 3'b001, 3'b010}; // RULE12
            ROUTE_MLH: srcLevel = '{3'b010, 3'b001, 3'b100}; // RULE13
            ROUTE_LHM: srcLevel = '{3'b001, 3'b100, 3'b010}; // RULE13
            ROUTE_LMH: srcLevel = '{3'b001, 3'b010, 3'b100}; // RULE13
            default: srcLevel = '{3'b000, 3'b000, 3'b000}; // RULE13
        endcase
    end

    // level requests from pending, masks and global enable
    always_comb begin
        nxt_lvlReq = ({3{hostPend}} & srcLevel[0]) | ({3{adcPend}} & srcLevel[1])
            | ({3{dacPend}} & srcLevel[2]);
        nxt_lvlReq = nxt_lvlReq & ctrl_ff[`BIT_MASK_HIGH:`BIT_MASK_LOW]; // RULE19
        if (!ctrl_ff[`BIT_GLOBAL_EN]) begin
            nxt_lvlReq = 3'b000; // RULE7
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lvlReq_ff <= 3'b000;
        end else begin
            lvlReq_ff <= nxt_lvlReq;
        end
    end

    // service arbitration: highest level first, no nesting
    always_ff @(posedge clk) begin
        if (!resetn) begin
            svc_ff <= SVC_IDLE;
            taken_ff <= 2'h0;
            takenValid_ff <= 1'b0;
        end else begin
            takenValid_ff <= 1'b0;
            unique case (svc_ff)
                SVC_IDLE: begin
                    if (lvlReq_ff != 3'b000) begin
                        svc_ff <= SVC_BUSY; // RULE16
                        takenValid_ff <= 1'b1;
                        if (lvlReq_ff[2]) begin
                            taken_ff <= 2'h2; // RULE16
                        end else if (lvlReq_ff[1]) begin
                            taken_ff <= 2'h1;
                        end else begin
                            taken_ff <= 2'h0;
                        end
                    end
                end
                SVC_BUSY: begin
                    if (serviceEnd) begin
                        svc_ff <= SVC_IDLE;
                    end
                end
                default: svc_ff <= SVC_IDLE;
            endcase
        end
    end

    // converter data: D/A load on write, done clear on read
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dac_ff <= 10'h000;
            dacLoad_ff <= 1'b0;
            convClr_ff <= 1'b0;
        end else begin
            dacLoad_ff <= dataWr;
            convClr_ff <= dataRd; // RULE18
            if (dataWr) begin
                dac_ff <= regWdata[`DAC_WIDTH-1:0]; // RULE14
            end
        end
    end

    // read data, registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_ff <= 16'h0000;
        end else if (ctrlSel && regRead) begin
            rdata_ff <= {hostPend, adcPend, dacPend, ctrl_ff[12:0]}; // RULE5 RULE9 RULE20
        end else if (dataRd) begin
            rdata_ff <= {6'h00, adcData, 2'h0}; // RULE15
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    // host view of bits 15 and 9
    logic [1:0] hostBits_ff;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hostBits_ff <= 2'h0;
        end else begin
            hostBits_ff <= {hostPend, cross_ff}; // RULE17
        end
    end

    assign regRdata = rdata_ff;
    assign hostReadBits = hostBits_ff;
    assign crossRequestToHost = cross_ff;
    assign dacData = dac_ff;
    assign dacLoad = dacLoad_ff;
    assign convDoneClear = convClr_ff;
    assign levelRequest = lvlReq_ff;
    assign levelTaken = taken_ff;
    assign levelTakenValid = takenValid_ff;

    // host acknowledge: the cross request drops once the delay fires
    sequence s_ack_fired;
        ackFire && !ctrlWr;
    endsequence
    sequence s_cross_dropped;
        !crossRequestToHost ##1 !hostReadBits[0];
    endsequence
    a_ack_clear: assert property (@(posedge clk) disable iff (!resetn) // RULE11
        s_ack_fired |=> s_cross_dropped) else $error("cross request not auto-cleared");

    // clear strobes and ignored writes on the pending flags
    a_host_clear: assert property (@(posedge clk) disable iff (!resetn) // RULE4
        ctrlWr && regWdata[`BIT_HOST_CLR] && !hostRequestSet |=> !hostPend)
        else $error("host flag not cleared");
    a_dac_clear: assert property (@(posedge clk) disable iff (!resetn) // RULE4
        ctrlWr && regWdata[`BIT_DAC_CLR] && !dacRateTick |=> !dacPend)
        else $error("dac flag not cleared");
    a_dac_kept: assert property (@(posedge clk) disable iff (!resetn) // RULE3
        ctrlWr && !regWdata[`BIT_DAC_CLR] && dacPend |=> dacPend)
        else $error("dac flag lost on write");

    // reset state and the host view
    a_ctrl_reset: assert property (@(posedge clk) disable iff (!resetn) // RULE8
        !$past(resetn) |-> !ctrl_ff[`BIT_GLOBAL_EN] && levelRequest == 3'b000)
        else $error("enable or request left after reset");
    a_host_view: assert property (@(posedge clk) disable iff (!resetn) // RULE17
        $past(resetn) |-> hostReadBits == $past({hostPend, crossRequestToHost}))
        else $error("host view wrong");

    // level requests follow masks and routing
    a_mask_levels: assert property (@(posedge clk) disable iff (!resetn) // RULE6
        (levelRequest & ~$past(ctrl_ff[`BIT_MASK_HIGH:`BIT_MASK_LOW])) == 3'b000)
        else $error("masked level requested");
    a_reserved_route: assert property (@(posedge clk) disable iff (!resetn) // RULE13
        $past(route == ROUTE_RSV6 || route == ROUTE_RSV7) |-> levelRequest == 3'b000)
        else $error("reserved routing requested");
    a_route_first: assert property (@(posedge clk) disable iff (!resetn) // RULE12
        $past(route == ROUTE_HML && hostPend && ctrl_ff[`BIT_MASK_HIGH]
            && ctrl_ff[`BIT_GLOBAL_EN]) |-> levelRequest[2])
        else $error("host not on high level");
    a_route_last: assert property (@(posedge clk) disable iff (!resetn) // RULE13
        $past(route == ROUTE_LMH && dacPend && ctrl_ff[`BIT_MASK_HIGH]
            && ctrl_ff[`BIT_GLOBAL_EN]) |-> levelRequest[2])
        else $error("dac not on high level");

    // pending flags, register view, gating and converter format
    a_host_set_only: assert property (@(posedge clk) disable iff (!resetn) // RULE1
        $rose(hostPend) |-> $past(hostRequestSet)) else $error("host flag set without request");
    a_adc_set: assert property (@(posedge clk) disable iff (!resetn) // RULE2
        adcValid |=> adcPend) else $error("adc flag not set");
    a_dac_set: assert property (@(posedge clk) disable iff (!resetn) // RULE3
        dacRateTick |=> dacPend) else $error("dac flag not set");
    a_clear_flag: assert property (@(posedge clk) disable iff (!resetn) // RULE4
        ctrlWr && regWdata[`BIT_ADC_CLR] && !adcValid |=> !adcPend)
        else $error("adc flag not cleared");
    a_read_zero: assert property (@(posedge clk) disable iff (!resetn) // RULE5
        $past(ctrlSel && regRead) |-> (regRdata[4:0] == 5'h00 && !regRdata[9]))
        else $error("virtual bits read nonzero");
    a_global_gate: assert property (@(posedge clk) disable iff (!resetn) // RULE7
        !$past(ctrl_ff[`BIT_GLOBAL_EN]) |-> levelRequest == 3'b000)
        else $error("request while globally disabled");
    a_cross_write: assert property (@(posedge clk) disable iff (!resetn) // RULE9
        ctrlWr |=> crossRequestToHost == $past(regWdata[`BIT_CROSS_REQ]))
        else $error("cross request wrong");
    a_no_nesting: assert property (@(posedge clk) disable iff (!resetn) // RULE16
        svc_ff == SVC_BUSY && !serviceEnd |=> !levelTakenValid) else $error("nested service");
    a_adc_format: assert property (@(posedge clk) disable iff (!resetn) // RULE15
        dataRd |=> regRdata == {6'h00, $past(adcData), 2'h0}) else $error("adc format");
    a_done_clear: assert property (@(posedge clk) disable iff (!resetn) // RULE18
        dataRd |=> convDoneClear) else $error("done clear missing");

    // arbitration: an idle arbiter takes the high level first
    sequence s_idle_high;
        svc_ff == SVC_IDLE && levelRequest[2];
    endsequence
    sequence s_take_high;
        levelTakenValid && levelTaken == 2'h2;
    endsequence
    a_take_high: assert property (@(posedge clk) disable iff (!resetn) // RULE16
        s_idle_high |=> s_take_high) else $error("high level not taken first");
    a_dac_load: assert property (@(posedge clk) disable iff (!resetn) // RULE14
        dataWr |=> dacLoad && dacData == $past(regWdata[`DAC_WIDTH-1:0]))
        else $error("dac load wrong");
endmodule

// ==== tb/host_model.sv ====
// control processor model: raises requests and acknowledges cross requests
`timescale 1ns/10ps
module host_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bench control
    input wire logic raise,
    input wire logic [7:0] ackWait,
    // device link
    input wire logic crossRequestToHost,
    output logic hostRequestSet,
    output logic hostAckWrite,
    output logic hostInstrStep
);
    int cnt;
    bit acked, phase, rq, cr, ack;
    // one instruction every other cycle, acknowledge ackWait cycles after a request
    initial begin
        {hostRequestSet, hostAckWrite, hostInstrStep} = 3'h0;
        forever begin
            @(posedge clk);
            rq = raise;
            cr = crossRequestToHost;
            #1;
            phase = resetn && !phase;
            ack = cr && resetn && !acked && cnt == ackWait;
            if (!cr || !resetn) begin
                acked = 0;
                cnt = 0;
            end else if (ack) begin
                acked = 1;
            end else begin
                cnt++;
            end
            hostRequestSet = rq && resetn;
            hostAckWrite = ack;
            hostInstrStep = phase && !ack;
        end
    end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the interrupt control and converter data block
`timescale 1ns/10ps
module tb;
    logic clk = 0, resetn = 0, ctrlSel = 0, dataSel = 0, regWrite = 0, regRead = 0;
    logic raise = 0, adcValid = 0, dacRateTick = 0, serviceEnd = 0, cdc;
    logic hostRequestSet, hostAckWrite, hostInstrStep, crossRequestToHost;
    logic dacLoad, convDoneClear, levelTakenValid;
    logic [15:0] regWdata = 16'h0000, regRdata, q;
    logic [1:0] hostReadBits, levelTaken;
    logic [2:0] levelRequest, tkn;
    logic [7:0] adcData = 8'hb7;
    logic [9:0] dacData;
    logic [8:0] rows [8] = '{9'h111, 9'h0a1, 9'h10a, 9'h08c, 9'h062, 9'h054, 9'h000, 9'h000};
    int mismatches = 0, tests_run = 0, n, k;

    // clock
    always #5 clk = ~clk;

    dsp_interrupt_and_converter_data u_dut (.clk(clk), .resetn(resetn), .ctrlSel(ctrlSel),
        .dataSel(dataSel), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .hostRequestSet(hostRequestSet), .hostAckWrite(hostAckWrite),
        .hostInstrStep(hostInstrStep), .hostReadBits(hostReadBits),
        .crossRequestToHost(crossRequestToHost), .adcValid(adcValid), .adcData(adcData),
        .dacRateTick(dacRateTick), .dacData(dacData), .dacLoad(dacLoad),
        .convDoneClear(convDoneClear), .serviceEnd(serviceEnd), .levelRequest(levelRequest),
        .levelTaken(levelTaken), .levelTakenValid(levelTakenValid));
    host_model u_host (.clk(clk), .resetn(resetn), .raise(raise), .ackWait(8'h14),
        .crossRequestToHost(crossRequestToHost), .hostRequestSet(hostRequestSet),
        .hostAckWrite(hostAckWrite), .hostInstrStep(hostInstrStep));

    // comparison, bus cycles and stimulus helpers
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic c, input logic [15:0] d);
        @(posedge clk);
        #1 {ctrlSel, dataSel, regWrite, regWdata} = {c, !c, 1'b1, d};
        @(posedge clk);
        #1 {ctrlSel, dataSel, regWrite} = 3'h0;
    endtask
    task rd(input logic c, output logic [15:0] r);
        @(posedge clk);
        #1 {ctrlSel, dataSel, regRead} = {c, !c, 1'b1};
        @(posedge clk);
        #1 {ctrlSel, dataSel, regRead} = 3'h0;
        r = regRdata;
        cdc = convDoneClear;
    endtask
    task fire(input int s);
        @(posedge clk);
        #1 {raise, adcValid, dacRateTick} = 3'h4 >> s;
        @(posedge clk);
        #1 {raise, adcValid, dacRateTick} = 3'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task se;
        @(posedge clk);
        #1 serviceEnd = 1;
        @(posedge clk);
        #1 serviceEnd = 0;
    endtask
    task tk(output logic [2:0] r);
        r = 3'h4;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (levelTakenValid === 1'b1 && r === 3'h4) r = {1'b0, levelTaken};
        end
    endtask
    task conclude;
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog
    initial begin
        #100000;
        mismatches++;
        conclude();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1 resetn = 1;
        rd(1, q);
        chk(q, 16'h0000);
        chk({levelRequest, crossRequestToHost}, 4'h0);
        $display("test reset done");
        for (int code = 0; code < 8; code++) begin
            for (int s = 0; s < 3; s++) begin
                wr(1, 16'h001c);
                se();
                wr(1, {8'h1d, 3'(code), 5'h1c});
                fire(s);
                chk(levelRequest, rows[code][8 - 3 * s -: 3]);
            end
        end
        $display("test routing done");
        wr(1, 16'hffff);
        rd(1, q);
        chk(q, 16'h1de0);
        chk({hostReadBits, crossRequestToHost}, 3'h3);
        {n, k} = 0;
        repeat (60) begin
            @(posedge clk);
            #2;
            if (hostAckWrite) k = 1;
            else if (k && crossRequestToHost && hostInstrStep) n++;
            else if (k && !crossRequestToHost) break;
        end
        chk(16'(n), 16'h0003);
        @(posedge clk);
        #1;
        chk({hostReadBits, crossRequestToHost}, 3'h0);
        wr(1, 16'h0200);
        chk(crossRequestToHost, 1'b1);
        wr(1, 16'h0000);
        chk(crossRequestToHost, 1'b0);
        $display("test cross request done");
        wr(1, 16'h0c00);
        fire(0);
        fire(2);
        chk(levelRequest, 3'h0);
        rd(1, q);
        chk(q, 16'hac00);
        chk(hostReadBits, 2'h2);
        wr(1, 16'h0d00);
        tk(tkn);
        chk(levelRequest, 3'h1);
        chk(tkn, 3'h0);
        wr(1, 16'h1d00);
        tk(tkn);
        chk(levelRequest, 3'h5);
        chk(tkn, 3'h4);
        se();
        tk(tkn);
        chk(tkn, 3'h2);
        $display("test priority done");
        wr(1, 16'h1d10);
        rd(1, q);
        chk(q, 16'h3d00);
        wr(1, 16'h0004);
        rd(1, q);
        chk(q, 16'h0000);
        $display("test clear done");
        wr(0, 16'hfd5a);
        chk(dacLoad, 1'b1);
        chk(dacData, 10'h15a);
        rd(0, q);
        chk(q, 16'h02dc);
        chk(cdc, 1'b1);
        $display("test converter done");
        wr(1, 16'h1d00);
        fire(1);
        chk(levelRequest, 3'h2);
        @(posedge clk);
        #1 resetn = 0;
        repeat (3) @(posedge clk);
        #1 resetn = 1;
        rd(1, q);
        chk(q, 16'h0000);
        chk({levelRequest, levelTakenValid, crossRequestToHost}, 5'h00);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
